// file: src/acr_clk_phase_bus_regs.sv
//----------------------------------------------------------------
//----------------------------------------------------------------
`default_nettype none

module acr_clk_phase_bus_regs
    import acr_pkg::*;
#(
    // Factory trimmed top offset bit, value arbitrary
    parameter logic OFS_MSB_DEFAULT = 1'b0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Serial configuration pins
    input wire logic sclk,
    input wire logic sen_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    // Register reset request and offset low byte from neighbours
    input wire logic reg_reset_req,
    input wire logic [7:0] offset_lsb,
    // Configuration outputs
    output logic bus_single,
    output logic [2:0] output_sample_clock_div,
    output logic [4:0] coarse_phase,
    output logic [5:0] fine_phase,
    output logic [ACR_DELAY_W-1:0] total_delay_fs,
    output logic [8:0] offset_word
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [ACR_DELAY_W-1:0] delay_fs(input logic [4:0] c,
                                                       input logic [5:0] f);
        int sum;
        sum = int'(c) * ACR_COARSE_STEP_FS + int'(f) * ACR_FINE_STEP_FS;
        return sum[ACR_DELAY_W-1:0];
    endfunction : delay_fs

    function automatic logic [2:0] div_ratio(input logic single, input logic by2);
        // Divide by four is refused while only bus A runs
        return (single || by2) ? ACR_DIV_BY2 : ACR_DIV_BY4;
    endfunction : div_ratio

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    acr_req_t req;
    logic [7:0] rdata;
    acr_cfg_t cfg_r;

    acr_serial_port u_port (
        .clk(clk),
        .arst_n(arst_n),
        .sclk(sclk),
        .sen_n(sen_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe_n(sdo_oe_n),
        .req(req),
        .rdata(rdata)
    );

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= '0;
            cfg_r.offset_msb <= OFS_MSB_DEFAULT;
        end else if (reg_reset_req) begin
            // Request is a pulse, so defaults are restored once
            cfg_r.bus_single <= ACR_RST_PHASE_COARSE_BUS[ACR_BUS_SINGLE_BIT];
            cfg_r.div_by2 <= ACR_RST_PHASE_COARSE_BUS[ACR_DIV_SEL_BIT];
            cfg_r.coarse_phase <= ACR_RST_PHASE_COARSE_BUS[ACR_COARSE_LSB +: ACR_COARSE_W];
            cfg_r.fine_phase <= ACR_RST_PHASE_FINE[ACR_FINE_LSB +: ACR_FINE_W];
            cfg_r.offset_msb <= OFS_MSB_DEFAULT;
        end else if (req.wr_stb) begin
            // Reserved bits are not stored and read back as zero
            if (req.addr == ACR_ADDR_PHASE_COARSE_BUS) begin
                cfg_r.bus_single <= req.wdata[ACR_BUS_SINGLE_BIT];
                cfg_r.div_by2 <= req.wdata[ACR_DIV_SEL_BIT];
                cfg_r.coarse_phase <= req.wdata[ACR_COARSE_LSB +: ACR_COARSE_W];
            end
            if (req.addr == ACR_ADDR_PHASE_FINE_OFS) begin
                cfg_r.fine_phase <= req.wdata[ACR_FINE_LSB +: ACR_FINE_W];
                cfg_r.offset_msb <= req.wdata[ACR_OFS_MSB_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata = 8'h00;
        if (req.addr == ACR_ADDR_PHASE_COARSE_BUS) begin
            rdata[ACR_BUS_SINGLE_BIT] = cfg_r.bus_single;
            rdata[ACR_DIV_SEL_BIT] = cfg_r.div_by2;
            rdata[ACR_COARSE_LSB +: ACR_COARSE_W] = cfg_r.coarse_phase;
        end else if (req.addr == ACR_ADDR_PHASE_FINE_OFS) begin
            rdata[ACR_OFS_MSB_BIT] = cfg_r.offset_msb;
            rdata[ACR_FINE_LSB +: ACR_FINE_W] = cfg_r.fine_phase;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_single <= 1'b0;
            output_sample_clock_div <= ACR_DIV_BY4;
            coarse_phase <= 5'h00;
            fine_phase <= 6'h00;
            total_delay_fs <= '0;
            offset_word <= {OFS_MSB_DEFAULT, 8'h00};
        end else begin
            bus_single <= cfg_r.bus_single;
            output_sample_clock_div <= div_ratio(cfg_r.bus_single, cfg_r.div_by2);
            coarse_phase <= cfg_r.coarse_phase;
            fine_phase <= cfg_r.fine_phase;
            total_delay_fs <= delay_fs(cfg_r.coarse_phase, cfg_r.fine_phase);
            offset_word <= {cfg_r.offset_msb, offset_lsb};
        end
    end

endmodule : acr_clk_phase_bus_regs

`default_nettype wire

// file: src/acr_pkg.sv
`default_nettype none

package acr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [6:0] ACR_ADDR_PHASE_COARSE_BUS = 7'h02;
    localparam logic [6:0] ACR_ADDR_PHASE_FINE_OFS = 7'h03;

    // Field positions, register clock_phase_coarse_and_bus_config
    localparam int ACR_BUS_SINGLE_BIT = 0;
    localparam int ACR_DIV_SEL_BIT = 1;
    localparam int ACR_COARSE_LSB = 3;
    localparam int ACR_COARSE_W = 5;

    // Field positions, register clock_phase_fine_and_offset_msb
    localparam int ACR_OFS_MSB_BIT = 0;
    localparam int ACR_FINE_LSB = 2;
    localparam int ACR_FINE_W = 6;

    // Values after reset
    localparam logic [7:0] ACR_RST_PHASE_COARSE_BUS = 8'h00;
    localparam logic [7:0] ACR_RST_PHASE_FINE = 8'h00;

    // Output clock ratios
    localparam logic [2:0] ACR_DIV_BY4 = 3'h4;
    localparam logic [2:0] ACR_DIV_BY2 = 3'h2;

    // Phase delay step sizes in femtoseconds
    localparam int ACR_COARSE_STEP_FS = 2400;
    localparam int ACR_FINE_STEP_FS = 116;
    localparam int ACR_DELAY_W = 17;

    // Serial frame: 1 direction bit, 7 address bits, 8 data bits
    localparam logic [4:0] ACR_FRAME_BITS = 5'h10;
    localparam logic [4:0] ACR_HDR_BITS = 5'h08;

    typedef struct packed {
        logic       bus_single;
        logic       div_by2;
        logic [4:0] coarse_phase;
        logic [5:0] fine_phase;
        logic       offset_msb;
    } acr_cfg_t;

    typedef struct packed {
        logic       wr_stb;
        logic       rd_stb;
        logic [6:0] addr;
        logic [7:0] wdata;
    } acr_req_t;

endpackage : acr_pkg

`default_nettype wire

// file: src/acr_serial_port.sv
`default_nettype none

module acr_serial_port
    import acr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Serial pins
    input wire logic sclk,
    input wire logic sen_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    // Register side
    output acr_req_t req,
    input wire logic [7:0] rdata
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_s_r;
    logic [1:0] sen_s_r;
    logic [1:0] sdi_s_r;
    logic sclk_d_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_s_r <= 2'h0;
            sen_s_r <= 2'h3;
            sdi_s_r <= 2'h0;
            sclk_d_r <= 1'b0;
        end else begin
            sclk_s_r <= {sclk_s_r[0], sclk};
            sen_s_r <= {sen_s_r[0], sen_n};
            sdi_s_r <= {sdi_s_r[0], sdi};
            sclk_d_r <= sclk_s_r[1];
        end
    end

    logic active;
    logic rise;
    logic fall;
    assign active = !sen_s_r[1];
    assign rise = active && sclk_s_r[1] && !sclk_d_r;
    assign fall = active && !sclk_s_r[1] && sclk_d_r;

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    logic [4:0] count_r;
    logic [14:0] shift_r;
    logic is_read_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= 5'h00;
            shift_r <= 15'h0000;
            is_read_r <= 1'b0;
            req <= '0;
        end else begin
            req.wr_stb <= 1'b0;
            req.rd_stb <= 1'b0;
            if (!active) begin
                count_r <= 5'h00;
                is_read_r <= 1'b0;
            end else if (rise && count_r < ACR_FRAME_BITS) begin
                shift_r <= {shift_r[13:0], sdi_s_r[1]};
                count_r <= count_r + 5'h01;
                if (count_r == ACR_HDR_BITS - 5'h01 && shift_r[6]) begin
                    is_read_r <= 1'b1;
                    req.rd_stb <= 1'b1;
                    req.addr <= {shift_r[5:0], sdi_s_r[1]};
                end
                if (count_r == ACR_FRAME_BITS - 5'h01 && !shift_r[14]) begin
                    req.wr_stb <= 1'b1;
                    req.addr <= shift_r[13:7];
                    req.wdata <= {shift_r[6:0], sdi_s_r[1]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read-back shifter, changes on falling serial clock
    // ------------------------------------------------------------
    logic [7:0] rd_shift_r;
    logic rd_load_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_shift_r <= 8'h00;
            rd_load_r <= 1'b0;
            sdo <= 1'b0;
            sdo_oe_n <= 1'b1;
        end else begin
            rd_load_r <= req.rd_stb;
            if (!active || !is_read_r) begin
                sdo_oe_n <= 1'b1;
                sdo <= 1'b0;
            end else if (rd_load_r) begin
                rd_shift_r <= rdata;
            end else if (fall && count_r >= ACR_HDR_BITS && count_r < ACR_FRAME_BITS) begin
                // Host samples each bit on the following rising edge
                sdo <= rd_shift_r[7];
                sdo_oe_n <= 1'b0;
                rd_shift_r <= {rd_shift_r[6:0], 1'b0};
            end
        end
    end

endmodule : acr_serial_port

`default_nettype wire

// file: testbench/acr_clk_phase_bus_regs_monitor.sv
`default_nettype none

module acr_clk_phase_bus_regs_monitor
    import acr_pkg::*;
#(
    parameter logic OFS_MSB_DEFAULT = 1'b0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Serial pins
    input wire logic sclk,
    input wire logic sen_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    // Neighbour inputs
    input wire logic reg_reset_req,
    input wire logic [7:0] offset_lsb,
    // Configuration outputs
    input wire logic bus_single,
    input wire logic [2:0] output_sample_clock_div,
    input wire logic [4:0] coarse_phase,
    input wire logic [5:0] fine_phase,
    input wire logic [ACR_DELAY_W-1:0] total_delay_fs,
    input wire logic [8:0] offset_word
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_div_single_bus: assert property (
        bus_single |-> output_sample_clock_div == ACR_DIV_BY2)
        else $error("divide by four while single bus");
    a_div_ratio_legal: assert property (
        output_sample_clock_div == ACR_DIV_BY2 || output_sample_clock_div == ACR_DIV_BY4)
        else $error("illegal divide ratio");
    a_delay_sum: assert property (
        total_delay_fs == coarse_phase * ACR_COARSE_STEP_FS + fine_phase * ACR_FINE_STEP_FS)
        else $error("total delay not coarse plus fine");
    a_offset_low_byte: assert property (
        $past(arst_n) |-> offset_word[7:0] == $past(offset_lsb))
        else $error("offset low byte not followed");
    a_reset_req_defaults: assert property (
        reg_reset_req |-> ##2 (!bus_single && coarse_phase == 5'h00 && fine_phase == 6'h00
        && output_sample_clock_div == ACR_DIV_BY4 && offset_word[8] == OFS_MSB_DEFAULT))
        else $error("register reset did not restore defaults");
    a_read_enable_start: assert property (
        $fell(sdo_oe_n) |-> !sen_n && !sclk)
        else $error("read driver enabled outside frame");
    a_read_enable_end: assert property (
        $rose(sen_n) |-> ##[0:5] sdo_oe_n)
        else $error("read driver held after frame");
    a_read_bit_steady: assert property (
        !sdo_oe_n && $past(sdo_oe_n) == 1'b0 && $changed(sdo) |-> !sclk)
        else $error("read data moved while serial clock high");

    c_reset_req: cover property (reg_reset_req);
    c_single_bus: cover property ($rose(bus_single));
    c_read_frame: cover property ($fell(sdo_oe_n));
endmodule : acr_clk_phase_bus_regs_monitor

bind acr_clk_phase_bus_regs acr_clk_phase_bus_regs_monitor
    #(.OFS_MSB_DEFAULT(OFS_MSB_DEFAULT)) u_monitor (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .sen_n(sen_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .reg_reset_req(reg_reset_req), .offset_lsb(offset_lsb),
    .bus_single(bus_single), .output_sample_clock_div(output_sample_clock_div),
    .coarse_phase(coarse_phase), .fine_phase(fine_phase),
    .total_delay_fs(total_delay_fs), .offset_word(offset_word));

`default_nettype wire

// file: testbench/acr_clk_phase_bus_regs_test.sv
`default_nettype none

module acr_clk_phase_bus_regs_test;
    import acr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_reset_req = 1'b0;
    logic [7:0] offset_lsb = 8'h5A;
    logic [7:0] r2 = ACR_RST_PHASE_COARSE_BUS;
    logic [7:0] r3 = ACR_RST_PHASE_FINE;
    wire logic sclk, sen_n, sdi, sdo, sdo_oe_n, bus_single;
    wire logic [2:0] output_sample_clock_div;
    wire logic [4:0] coarse_phase;
    wire logic [5:0] fine_phase;
    wire logic [ACR_DELAY_W-1:0] total_delay_fs;
    wire logic [8:0] offset_word;
    int n_mismatch = 0;
    int compares = 0;
    // Reserved bits kept at zero in every written value
    logic [14:0] wlist [8] = '{15'h020B, 15'h02FA, 15'h02F8, 15'h0201,
                                15'h03FD, 15'h0300, 15'h03A9, 15'h02F9};

    acr_host_model u_host (.clk(clk), .sclk(sclk), .sen_n(sen_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n));
    acr_clk_phase_bus_regs u_dut (.clk(clk), .arst_n(arst_n), .sclk(sclk),
        .sen_n(sen_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .reg_reset_req(reg_reset_req), .offset_lsb(offset_lsb), .bus_single(bus_single),
        .output_sample_clock_div(output_sample_clock_div), .coarse_phase(coarse_phase),
        .fine_phase(fine_phase), .total_delay_fs(total_delay_fs), .offset_word(offset_word));

    initial forever #5 clk = ~clk;

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] q;
        u_host.xfer(1'b1, a, 8'h00, q);
        check("readback", q, exp);
    endtask : rd

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.xfer(1'b0, a, d, q);
        if (a == ACR_ADDR_PHASE_COARSE_BUS) r2 = d;
        if (a == ACR_ADDR_PHASE_FINE_OFS) r3 = d;
    endtask : wr

    task automatic check_outs();
        check("bus_single", bus_single, r2[0]);
        check("div", output_sample_clock_div, (r2[1] | r2[0]) ? ACR_DIV_BY2 : ACR_DIV_BY4);
        check("coarse", coarse_phase, r2[7:3]);
        check("fine", fine_phase, r3[7:2]);
        check("delay", total_delay_fs, r2[7:3] * ACR_COARSE_STEP_FS + r3[7:2] * ACR_FINE_STEP_FS);
        check("offset", offset_word, {r3[0], offset_lsb});
    endtask : check_outs

    initial begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        check_outs();
        rd(ACR_ADDR_PHASE_COARSE_BUS, ACR_RST_PHASE_COARSE_BUS);
        rd(ACR_ADDR_PHASE_FINE_OFS, ACR_RST_PHASE_FINE);
        foreach (wlist[i]) begin
            wr(wlist[i][14:8], wlist[i][7:0]);
            rd(wlist[i][14:8], wlist[i][7:0]);
            check_outs();
        end
        wr(7'h05, 8'hFF);
        rd(7'h05, 8'h00);
        check_outs();
        offset_lsb = 8'hC3;
        repeat (2) @(negedge clk);
        check_outs();
        reg_reset_req = 1'b1;
        @(negedge clk);
        reg_reset_req = 1'b0;
        repeat (3) @(negedge clk);
        r2 = ACR_RST_PHASE_COARSE_BUS;
        r3 = ACR_RST_PHASE_FINE;
        check_outs();
        rd(ACR_ADDR_PHASE_COARSE_BUS, ACR_RST_PHASE_COARSE_BUS);
        rd(ACR_ADDR_PHASE_FINE_OFS, ACR_RST_PHASE_FINE);
        summarize();
    end

    initial begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule : acr_clk_phase_bus_regs_test

`default_nettype wire

// file: testbench/acr_host_model.sv
`default_nettype none

module acr_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output var logic sclk,
    output var logic sen_n,
    output var logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Margin over the 3 cycle minimum so the synced edges settle
    localparam int HALF = 6;

    initial begin
        sclk = 1'b0;
        sen_n = 1'b1;
        sdi = 1'b0;
    end

    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        q = 8'h00;
        @(negedge clk) sen_n <= 1'b0;
        repeat (HALF) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            sclk <= 1'b0;
            sdi <= f[i];
            repeat (HALF) @(negedge clk);
            // Released line has no pull, so show the inverse of the last bit
            if (i < 8) q[i] = sdo_oe_n ? ~sdo : sdo;
            sclk <= 1'b1;
            repeat (HALF) @(negedge clk);
        end
        sclk <= 1'b0;
        repeat (HALF) @(negedge clk);
        sen_n <= 1'b1;
        // Idle data line toggles so nothing relies on a stale bit
        repeat (8) begin
            @(negedge clk);
            sdi <= ~sdi;
        end
    endtask : xfer
endmodule : acr_host_model

`default_nettype wire
